// File: logic/hps_sequencer.sv
`timescale 1ns/10ps
// Function
// - Each of the two regulators has an internal good flag raised when its output reaches the rise threshold.
// - A good flag is cleared when its regulator output falls to the lower fall threshold, giving hysteresis.
// - A good flag follows a threshold crossing within 10 us in either direction.
// - The good flags stay internal and drive only the sequencing, never a pin.
// - At power-up, after the first good flag rises, wait the regulator delay and enable the second regulator.
// - At power-up, after the second good flag rises, wait the reset delay and release reset high.
// - At power-down, after reset goes low, wait the reset delay and disable the second regulator.
// - At power-down, after the second good flag falls, wait the regulator delay and disable the first regulator.
// - A key press held for the debounce time asserts the key interrupt and starts power-up.
// - A charger detect falling while off starts power-up after the debounce time with the interrupt left high.
// - After reset release the host must raise hold within the timeout, else interrupt clears and power goes down unless the charger is detected.
// - Either good flag falling while running drives reset low at once and powers down.
module hps_sequencer #(
	parameter int TICK_CYCLES     = hps_pkg::TICK_CYCLES,
	parameter int DEBOUNCE_US     = hps_pkg::DEBOUNCE_US,
	parameter int REG_DELAY_US    = hps_pkg::REG_DELAY_STD_US,
	parameter int RESET_DELAY_US  = hps_pkg::RESET_DELAY_US,
	parameter int HOLD_TIMEOUT_US = hps_pkg::HOLD_TIMEOUT_US
) (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic reset_in,
	// Wake sources and host request
	input  wire logic power_key_in,
	input  wire logic charger_detect_n_in,
	input  wire logic host_hold_power_request_in,
	// Regulator comparator levels
	input  wire logic first_regulator_above_rise_in,
	input  wire logic first_regulator_below_fall_in,
	input  wire logic second_regulator_above_rise_in,
	input  wire logic second_regulator_below_fall_in,
	// Regulator enables and host signals
	output logic      first_regulator_enable_out,
	output logic      second_regulator_enable_out,
	output logic      host_reset_n_out,
	output logic      key_irq_n_out
);
	localparam int TW = hps_pkg::TIME_W;

	// Timer end test on a microsecond tick
	function automatic logic timer_done(input logic [TW-1:0] count, input int limit_us, input logic tick);
		timer_done = tick && (count >= TW'(limit_us - 1));
	endfunction

	// Good flags, internal only
	hps_flag_if first_flag ();
	hps_flag_if second_flag ();
	assign first_flag.above_rise  = first_regulator_above_rise_in;
	assign first_flag.below_fall  = first_regulator_below_fall_in;
	assign second_flag.above_rise = second_regulator_above_rise_in;
	assign second_flag.below_fall = second_regulator_below_fall_in;

	hps_good_flag u_first_flag (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.cmp      (first_flag.flag)
	);
	hps_good_flag u_second_flag (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.cmp      (second_flag.flag)
	);

	wire logic first_good;
	wire logic second_good;
	assign first_good  = first_flag.good;
	assign second_good = second_flag.good;

	// Microsecond tick divider
	localparam int KW = hps_pkg::TICK_W;
	logic [KW-1:0] tick_count;
	wire logic     tick;
	assign tick = (tick_count == KW'(TICK_CYCLES - 1));

	always_ff @(posedge clk_in) begin
		if (reset_in || tick) begin
			tick_count <= '0;
		end else begin
			tick_count <= tick_count + 1'b1;
		end
	end

	// State, timer and output registers
	hps_pkg::hps_state_t state;
	hps_pkg::hps_state_t next_state;
	logic [TW-1:0]       timer;
	logic                from_key;
	logic                next_from_key;
	logic                next_first_en;
	logic                next_second_en;
	logic                next_reset_n;
	logic                next_irq_n;

	// Wake and shutdown conditions
	wire logic wake_key;
	wire logic wake_charger;
	wire logic source_held;
	wire logic charger_in;
	wire logic rail_lost;
	assign wake_key     = power_key_in;
	assign wake_charger = !charger_detect_n_in;
	assign charger_in   = !charger_detect_n_in;
	assign source_held  = from_key ? power_key_in : wake_charger;
	assign rail_lost    = !first_good || !second_good;

	// Next state and next outputs
	always_comb begin
		next_state     = state;
		next_from_key  = from_key;
		next_first_en  = first_regulator_enable_out;
		next_second_en = second_regulator_enable_out;
		next_reset_n   = host_reset_n_out;
		next_irq_n     = key_irq_n_out;
		case (state)
			hps_pkg::HPS_OFF: begin
				next_first_en  = 1'b0;
				next_second_en = 1'b0;
				next_reset_n   = 1'b0;
				next_irq_n     = 1'b1;
				if (wake_key || wake_charger) begin
					next_from_key = wake_key;
					next_state    = hps_pkg::HPS_DEBOUNCE;
				end
			end
			hps_pkg::HPS_DEBOUNCE: begin
				if (!source_held) begin
					next_state = hps_pkg::HPS_OFF;
				end else if (timer_done(timer, DEBOUNCE_US, tick)) begin
					next_first_en = 1'b1;
					next_irq_n    = !from_key;
					next_state    = hps_pkg::HPS_FIRST_UP;
				end
			end
			hps_pkg::HPS_FIRST_UP: begin
				if (first_good) begin
					next_state = hps_pkg::HPS_REG_DLY_UP;
				end
			end
			hps_pkg::HPS_REG_DLY_UP: begin
				if (timer_done(timer, REG_DELAY_US, tick)) begin
					next_second_en = 1'b1;
					next_state     = hps_pkg::HPS_SECOND_UP;
				end
			end
			hps_pkg::HPS_SECOND_UP: begin
				if (second_good) begin
					next_state = hps_pkg::HPS_RST_DLY_UP;
				end
			end
			hps_pkg::HPS_RST_DLY_UP: begin
				if (timer_done(timer, RESET_DELAY_US, tick)) begin
					next_reset_n = 1'b1;
					next_state   = hps_pkg::HPS_HOLD_WAIT;
				end
			end
			hps_pkg::HPS_HOLD_WAIT: begin
				if (rail_lost) begin
					next_reset_n = 1'b0;
					next_irq_n   = 1'b1;
					next_state   = hps_pkg::HPS_RST_DLY_DN;
				end else if (host_hold_power_request_in) begin
					next_irq_n = 1'b1;
					next_state = hps_pkg::HPS_RUN;
				end else if (timer_done(timer, HOLD_TIMEOUT_US, tick)) begin
					next_irq_n = 1'b1;
					if (charger_in) begin
						next_state = hps_pkg::HPS_RUN;
					end else begin
						next_reset_n = 1'b0;
						next_state   = hps_pkg::HPS_RST_DLY_DN;
					end
				end
			end
			hps_pkg::HPS_RUN: begin
				if (rail_lost || (!host_hold_power_request_in && !charger_in)) begin
					next_reset_n = 1'b0;
					next_state   = hps_pkg::HPS_RST_DLY_DN;
				end
			end
			hps_pkg::HPS_RST_DLY_DN: begin
				if (timer_done(timer, RESET_DELAY_US, tick)) begin
					next_second_en = 1'b0;
					next_state     = hps_pkg::HPS_SECOND_DN;
				end
			end
			hps_pkg::HPS_SECOND_DN: begin
				if (!second_good) begin
					next_state = hps_pkg::HPS_REG_DLY_DN;
				end
			end
			hps_pkg::HPS_REG_DLY_DN: begin
				if (timer_done(timer, REG_DELAY_US, tick)) begin
					next_first_en = 1'b0;
					next_state    = hps_pkg::HPS_OFF;
				end
			end
			default: begin
				next_state = hps_pkg::HPS_OFF;
			end
		endcase
	end

	// Timer restarts on every state change, counts microsecond ticks
	always_ff @(posedge clk_in) begin
		if (reset_in || (next_state != state)) begin
			timer <= '0;
		end else if (tick && (timer != {TW{1'b1}})) begin
			timer <= timer + 1'b1;
		end
	end

	// State and output registers
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state                       <= hps_pkg::HPS_OFF;
			from_key                    <= 1'b0;
			first_regulator_enable_out  <= 1'b0;
			second_regulator_enable_out <= 1'b0;
			host_reset_n_out            <= 1'b0;
			key_irq_n_out               <= 1'b1;
		end else begin
			state                       <= next_state;
			from_key                    <= next_from_key;
			first_regulator_enable_out  <= next_first_en;
			second_regulator_enable_out <= next_second_en;
			host_reset_n_out            <= next_reset_n;
			key_irq_n_out               <= next_irq_n;
		end
	end
endmodule

// File: logic/hps_pkg.sv
package hps_pkg;
	// Clock and timebase
	localparam int CLK_PERIOD_NS = 4;
	localparam int TICK_NS       = 1000;
	localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
	localparam int TICK_W        = 8;

	// Sequencing times in microseconds
	localparam int DEBOUNCE_US      = 32000;
	localparam int REG_DELAY_STD_US = 125;
	localparam int REG_DELAY_OPT_US = 10000;
	localparam int RESET_DELAY_US   = 20000;
	localparam int HOLD_TIMEOUT_US  = 500000;
	localparam int TIME_W           = 20;

	// Good flag reaction bound in nanoseconds, and its cycle count
	localparam int FLAG_MAX_NS     = 10000;
	localparam int FLAG_MAX_CYCLES = FLAG_MAX_NS / CLK_PERIOD_NS;

	// Sequencer states
	typedef enum logic [3:0] {
		HPS_OFF        = 4'h0,
		HPS_DEBOUNCE   = 4'h1,
		HPS_FIRST_UP   = 4'h2,
		HPS_REG_DLY_UP = 4'h3,
		HPS_SECOND_UP  = 4'h4,
		HPS_RST_DLY_UP = 4'h5,
		HPS_HOLD_WAIT  = 4'h6,
		HPS_RUN        = 4'h7,
		HPS_RST_DLY_DN = 4'h8,
		HPS_SECOND_DN  = 4'h9,
		HPS_REG_DLY_DN = 4'ha
	} hps_state_t;
endpackage

// File: logic/hps_flag_if.sv
`timescale 1ns/10ps
interface hps_flag_if;
	logic above_rise;
	logic below_fall;
	logic good;

	modport flag (input above_rise, input below_fall, output good);
	modport user (output above_rise, output below_fall, input good);
endinterface

// File: logic/hps_good_flag.sv
`timescale 1ns/10ps
module hps_good_flag (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic reset_in,
	// Comparator side and flag
	hps_flag_if.flag  cmp
);
	// Hysteresis: set at rise threshold, clear at fall threshold, else hold
	logic next_good;
	assign next_good = cmp.below_fall ? 1'b0 : (cmp.above_rise ? 1'b1 : cmp.good);

	// One cycle reaction, far inside the bound
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cmp.good <= 1'b0;
		end else begin
			cmp.good <= next_good;
		end
	end
endmodule

// File: tb/hps_host_model.sv
`timescale 1ns/10ps
module hps_host_model (
	// Clock and host reset
	input  wire logic clk_in,
	input  wire logic host_reset_n_in,
	// Bench command and hold request
	input  wire logic answer_in,
	output logic      hold_out
);
	int wait_cnt = 0;
	initial hold_out = 1'b0;
	// Boot takes a few cycles, then hold follows the command
	always @(posedge clk_in) begin
		wait_cnt <= host_reset_n_in ? wait_cnt + 1 : 0;
		hold_out <= host_reset_n_in && answer_in && wait_cnt >= 6;
	end
endmodule

// File: tb/hps_sequencer_monitor.sv
`timescale 1ns/10ps
module hps_sequencer_monitor #(
	parameter int TICK_CYCLES     = 250,
	parameter int DEBOUNCE_US     = 32000,
	parameter int REG_DELAY_US    = 125,
	parameter int RESET_DELAY_US  = 20000,
	parameter int HOLD_TIMEOUT_US = 500000
) (
	// Clock, reset and inputs
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic power_key_in,
	input wire logic charger_detect_n_in,
	input wire logic host_hold_power_request_in,
	input wire logic first_regulator_above_rise_in,
	input wire logic first_regulator_below_fall_in,
	input wire logic second_regulator_above_rise_in,
	input wire logic second_regulator_below_fall_in,
	// Outputs
	input wire logic first_regulator_enable_out,
	input wire logic second_regulator_enable_out,
	input wire logic host_reset_n_out,
	input wire logic key_irq_n_out
);
	localparam int RG = (REG_DELAY_US - 1) * TICK_CYCLES;
	localparam int RS = (RESET_DELAY_US - 1) * TICK_CYCLES;
	localparam int HT = HOLD_TIMEOUT_US * TICK_CYCLES + 2;
	int hi_cnt;
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// Cycles released with the interrupt still low
	always_ff @(posedge clk_in) begin
		hi_cnt <= (!reset_in && host_reset_n_out && !key_irq_n_out) ? hi_cnt + 1 : 0;
	end
	a_wake_held: assert property ($rose(first_regulator_enable_out) |-> $past(power_key_in || !charger_detect_n_in))
		else $error("first enable without wake");
	a_irq_with_first: assert property ($fell(key_irq_n_out) |-> $rose(first_regulator_enable_out))
		else $error("irq without first enable");
	a_charger_quiet: assert property ($rose(first_regulator_enable_out) && !$past(power_key_in) |-> key_irq_n_out)
		else $error("irq on charger wake");
	a_second_delay: assert property ($rose(second_regulator_enable_out) |-> $past(first_regulator_above_rise_in, RG))
		else $error("second enable early");
	a_reset_delay: assert property ($rose(host_reset_n_out) |-> $past(second_regulator_above_rise_in, RS))
		else $error("reset released early");
	a_second_off: assert property ($fell(second_regulator_enable_out) |-> $past(!host_reset_n_out, RS))
		else $error("second off early");
	a_first_off: assert property ($fell(first_regulator_enable_out) |-> $past(second_regulator_below_fall_in, RG))
		else $error("first off early");
	a_rail_loss: assert property (host_reset_n_out &&
		(first_regulator_below_fall_in || second_regulator_below_fall_in) |-> ##[1:2] !host_reset_n_out)
		else $error("reset kept on rail loss");
	a_hold_drop: assert property ($fell(host_hold_power_request_in) &&
		host_reset_n_out && charger_detect_n_in |-> ##[1:2] !host_reset_n_out)
		else $error("reset kept on hold drop");
	a_hold_timeout: assert property (hi_cnt <= HT)
		else $error("hold wait too long");
	c_released: cover property ($rose(host_reset_n_out));
	c_irq_cleared: cover property (host_reset_n_out && $rose(key_irq_n_out));
	c_powered_off: cover property ($fell(first_regulator_enable_out));
endmodule
bind hps_sequencer hps_sequencer_monitor #(
	.TICK_CYCLES     (TICK_CYCLES),
	.DEBOUNCE_US     (DEBOUNCE_US),
	.REG_DELAY_US    (REG_DELAY_US),
	.RESET_DELAY_US  (RESET_DELAY_US),
	.HOLD_TIMEOUT_US (HOLD_TIMEOUT_US)
) mon (
	.clk_in                         (clk_in),
	.reset_in                       (reset_in),
	.power_key_in                   (power_key_in),
	.charger_detect_n_in            (charger_detect_n_in),
	.host_hold_power_request_in     (host_hold_power_request_in),
	.first_regulator_above_rise_in  (first_regulator_above_rise_in),
	.first_regulator_below_fall_in  (first_regulator_below_fall_in),
	.second_regulator_above_rise_in (second_regulator_above_rise_in),
	.second_regulator_below_fall_in (second_regulator_below_fall_in),
	.first_regulator_enable_out     (first_regulator_enable_out),
	.second_regulator_enable_out    (second_regulator_enable_out),
	.host_reset_n_out               (host_reset_n_out),
	.key_irq_n_out                  (key_irq_n_out)
);

// File: tb/tb.sv
`timescale 1ns/10ps
module tb;
	logic      clk = 0, rst = 1, key = 0, chg_n = 1, answer = 0;
	logic      f_up = 0, f_dn = 1, s_up = 0, s_dn = 1;
	logic      hold;
	wire logic f_en, s_en, rst_n, irq_n;
	wire logic [3:0] outs = {f_en, s_en, rst_n, irq_n};
	string     nm[4] = '{"irq_n", "rst_n", "s_en", "f_en"};
	int        n_errors = 0, n_checks = 0;
	always #2 clk = ~clk;
	hps_sequencer #(.TICK_CYCLES(4), .DEBOUNCE_US(5), .REG_DELAY_US(3), .RESET_DELAY_US(4), .HOLD_TIMEOUT_US(20)) DUT (
		.clk_in(clk), .reset_in(rst), .power_key_in(key), .charger_detect_n_in(chg_n),
		.host_hold_power_request_in(hold), .first_regulator_above_rise_in(f_up), .first_regulator_below_fall_in(f_dn),
		.second_regulator_above_rise_in(s_up), .second_regulator_below_fall_in(s_dn),
		.first_regulator_enable_out(f_en), .second_regulator_enable_out(s_en), .host_reset_n_out(rst_n),
		.key_irq_n_out(irq_n));
	hps_host_model host (.clk_in(clk), .host_reset_n_in(rst_n), .answer_in(answer), .hold_out(hold));
	task check(input string name, input logic seen, input logic exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %b seen %b", name, exp, seen);
		end
	endtask
	task results;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Output holds its old level for early cycles, then reaches v within lim
	task step(input int idx, input logic v, input int early, input int lim);
		int i;
		repeat (early) begin
			@(negedge clk);
			check(nm[idx], outs[idx], !v);
		end
		for (i = 0; i < lim && outs[idx] !== v; i++)
			@(negedge clk);
		check(nm[idx], outs[idx], v);
		if (outs[idx] !== v)
			results;
	endtask
	// Power-up from key or charger, up to reset release
	task power_up(input logic by_key);
		key = by_key;
		chg_n = by_key;
		step(3, 1'b1, 12, 20);
		check("irq_n", irq_n, !by_key);
		key = 0;
		f_dn = 0;
		f_up = 1;
		step(2, 1'b1, 6, 20);
		s_dn = 0;
		s_up = 1;
		step(1, 1'b1, 10, 25);
	endtask
	// Reverse sequence once reset is low
	task rails_down;
		step(2, 1'b0, 10, 20);
		s_up = 0;
		s_dn = 1;
		step(3, 1'b0, 6, 20);
		f_up = 0;
		f_dn = 1;
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rst = 0;
		// Key released inside the debounce is ignored
		key = 1;
		repeat (10) @(negedge clk);
		key = 0;
		repeat (30) @(negedge clk);
		check("f_en", f_en, 1'b0);
		// Key power-up, hold answered, hold drop powers down
		answer = 1;
		power_up(1'b1);
		step(0, 1'b1, 0, 12);
		answer = 0;
		step(1, 1'b0, 0, 4);
		rails_down;
		// Hold never raised: timeout reasserts reset
		power_up(1'b1);
		step(1, 1'b0, 60, 30);
		check("irq_n", irq_n, 1'b1);
		rails_down;
		// Rail loss while running
		answer = 1;
		power_up(1'b1);
		step(0, 1'b1, 0, 12);
		f_up = 0;
		repeat (5) @(negedge clk);
		check("rst_n", rst_n, 1'b1);
		f_dn = 1;
		step(1, 1'b0, 0, 3);
		rails_down;
		// Charger wake, hold never raised: charger keeps power past the hold timeout
		power_up(1'b0);
		answer = 0;
		step(1, 1'b1, 0, 0);
		repeat (100) @(negedge clk);
		check("rst_n", rst_n, 1'b1);
		check("irq_n", irq_n, 1'b1);
		chg_n = 1;
		step(1, 1'b0, 0, 4);
		rails_down;
		results;
	end
endmodule
